/* File: airs_dev.sv */
// Converter end: conversion sequencing and read-only serial slave
//
// Behaviour
// - Cycle conversion, sleep, output in order
// - Finished conversion enters sleep automatically
// - Sleep holds result until read
// - Addressed while converting: no acknowledge
// - Address 0010100 plus read bit selects
// - Ready and addressed: pull ack low
// - Sixteen bits MSB first, change on fall
// - First bit is sign, one when non-negative
// - Stop after read or 16 bits restarts
// - Offset binary, mid 32768, clamp 0..65535
// - Power-on hold 0.5ms then convert
// - Detect start and stop conditions
// - Repeated start acts as start
// - Nine clocks: eight bits plus ack
// - Data changes only while clock low
// - Data line only pulled low or released
// - Slave only, clock input, result only
// - Up to 400kbit/s fast mode
// - Sample incoming bits on rising clock
// - Release line except ack and output
// - Address, ack, stop discards and reconverts when first result bit is 1; a 0 holds data low, blocking the stop
`timescale 1ns/1ps
`default_nettype none
`include "airs_defs.svh"
module airs_dev
  import airs_pkg::*;
#(
  parameter int unsigned POR_CYCLES  = `AIRS_POR_CYCLES,
  parameter int unsigned CONV_CYCLES = `AIRS_CONV_CYCLES
) (
  input  wire logic               core_clk,
  input  wire logic               rst,
  airs_if.dev                     bus,
  input  wire logic signed [19:0] diff_in,
  output logic                    conv_busy,
  output logic                    result_new,
  output logic             [15:0] result_code
);

  // ------------------------------------------------------------
  // Pin synchronisers and condition detection
  // ------------------------------------------------------------
  logic scl_m1, scl_m2, scl_d;
  logic sda_m1, sda_m2, sda_d;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      scl_m1 <= 1'b1;
      scl_m2 <= 1'b1;
      scl_d  <= 1'b1;
      sda_m1 <= 1'b1;
      sda_m2 <= 1'b1;
      sda_d  <= 1'b1;
    end else begin
      scl_m1 <= bus.scl;
      scl_m2 <= scl_m1;
      scl_d  <= scl_m2;
      sda_m1 <= bus.sda;
      sda_m2 <= sda_m1;
      sda_d  <= sda_m2;
    end
  end

  // Clock is only ever sampled; this end never drives it
  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise  = scl_m2 & ~scl_d;
  assign scl_fall  = ~scl_m2 & scl_d;
  assign start_det = scl_m2 & scl_d & sda_d & ~sda_m2;
  assign stop_det  = scl_m2 & scl_d & ~sda_d & sda_m2;

  // ------------------------------------------------------------
  // Power-on hold and conversion timing
  // ------------------------------------------------------------
  airs_dev_state_t  dstate_r;
  airs_link_state_t lstate_r;
  logic [22:0]      por_cnt_r;
  logic             por_done_r;
  logic [22:0]      conv_cnt_r;
  logic             kick_r;
  logic             ack_go;
  logic             conv_end;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      por_cnt_r  <= 23'h000000;
      por_done_r <= 1'b0;
    end else if (!por_done_r) begin
      por_cnt_r  <= por_cnt_r + 23'h000001;
      por_done_r <= (por_cnt_r == 23'(POR_CYCLES - 1));
    end
  end

  assign conv_end = por_done_r && (conv_cnt_r == 23'(CONV_CYCLES - 1));

  always_ff @(posedge core_clk) begin
    if (rst || dstate_r != DEV_CONV || !por_done_r) begin
      conv_cnt_r <= 23'h000000;
    end else begin
      conv_cnt_r <= conv_cnt_r + 23'h000001;
    end
  end

  // ------------------------------------------------------------
  // Result coding
  // ------------------------------------------------------------
  // Offset binary with clamping; the sign falls out as bit 15
  // One guard bit so a near full-scale input cannot wrap past the clamp
  logic signed [20:0] code_sum;
  logic        [15:0] code_clamped;
  assign code_sum = 21'(diff_in) + 21'(`AIRS_MID_SCALE);

  always_comb begin
    if (code_sum < 21'sh00000) begin
      code_clamped = 16'h0000;
    end else if (code_sum > 21'(`AIRS_FULL_SCALE)) begin
      code_clamped = 16'hffff;
    end else begin
      code_clamped = code_sum[15:0];
    end
  end

  // ------------------------------------------------------------
  // Operating state
  // ------------------------------------------------------------
  logic [15:0] result_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      dstate_r <= DEV_CONV;
      result_r <= 16'h0000;
    end else begin
      case (dstate_r)
        DEV_CONV: begin
          if (conv_end) begin
            result_r <= code_clamped;
            dstate_r <= DEV_SLEEP;
          end
        end
        DEV_SLEEP: begin
          // Held indefinitely; only a read moves it on
          if (kick_r) begin
            dstate_r <= DEV_CONV;
          end else if (ack_go) begin
            dstate_r <= DEV_OUTPUT;
          end
        end
        DEV_OUTPUT: begin
          if (kick_r) begin
            dstate_r <= DEV_CONV;
          end
        end
        default: dstate_r <= DEV_CONV;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Serial slave
  // ------------------------------------------------------------
  logic [4:0]  cnt_r;
  logic [7:0]  sr_r;
  logic [15:0] sh_r;
  logic        sda_low_r;
  logic        acked_r;
  logic [7:0]  addr_word;

  assign addr_word = {sr_r[6:0], sda_m2};
  assign ack_go    = (lstate_r == L_ACKH) && scl_fall;

  // All line changes happen on a detected falling clock edge
  always_ff @(posedge core_clk) begin
    if (rst) begin
      lstate_r  <= L_IDLE;
      cnt_r     <= 5'h00;
      sr_r      <= 8'h00;
      sh_r      <= 16'h0000;
      sda_low_r <= 1'b0;
      acked_r   <= 1'b0;
      kick_r    <= 1'b0;
    end else begin
      kick_r <= 1'b0;
      if (start_det) begin
        lstate_r  <= L_ADDR;
        cnt_r     <= 5'h00;
        sda_low_r <= 1'b0;
        acked_r   <= 1'b0;
      end else if (stop_det) begin
        lstate_r  <= L_IDLE;
        sda_low_r <= 1'b0;
        kick_r    <= acked_r;
        acked_r   <= 1'b0;
      end else begin
        case (lstate_r)
          L_ADDR: begin
            if (scl_rise) begin
              sr_r  <= addr_word;
              cnt_r <= cnt_r + 5'h01;
              if (cnt_r == `AIRS_BYTE_BITS - 5'h01) begin
                // Ready only outside conversion
                if (addr_word == `AIRS_ADDR_RD && dstate_r != DEV_CONV) begin
                  lstate_r <= L_ACK;
                end else begin
                  lstate_r <= L_IGNORE;
                end
              end
            end
          end
          L_ACK: begin
            if (scl_fall) begin
              sda_low_r <= 1'b1;
              lstate_r  <= L_ACKH;
            end
          end
          L_ACKH: begin
            if (scl_fall) begin
              sda_low_r <= ~result_r[15];
              sh_r      <= {result_r[14:0], 1'b0};
              cnt_r     <= 5'h01;
              acked_r   <= 1'b1;
              lstate_r  <= L_DATA;
            end
          end
          L_DATA: begin
            if (scl_fall) begin
              if (cnt_r == `AIRS_RES_BITS) begin
                sda_low_r <= 1'b0;
                kick_r    <= 1'b1;
                acked_r   <= 1'b0;
                lstate_r  <= L_IGNORE;
              end else if (cnt_r == `AIRS_BYTE_BITS) begin
                sda_low_r <= 1'b0;
                lstate_r  <= L_MACK;
              end else begin
                sda_low_r <= ~sh_r[15];
                sh_r      <= {sh_r[14:0], 1'b0};
                cnt_r     <= cnt_r + 5'h01;
              end
            end
          end
          L_MACK: begin
            if (scl_fall) begin
              sda_low_r <= ~sh_r[15];
              sh_r      <= {sh_r[14:0], 1'b0};
              cnt_r     <= cnt_r + 5'h01;
              lstate_r  <= L_DATA;
            end
          end
          L_IGNORE: sda_low_r <= 1'b0;
          L_IDLE:   sda_low_r <= 1'b0;
          default:  lstate_r  <= L_IDLE;
        endcase
      end
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  // Open drain: output level is a constant low, only the enable moves
  logic sda_o_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      sda_o_r     <= 1'b0;
      conv_busy   <= 1'b1;
      result_new  <= 1'b0;
      result_code <= 16'h0000;
    end else begin
      sda_o_r     <= 1'b0;
      conv_busy   <= (dstate_r == DEV_CONV);
      result_new  <= (dstate_r == DEV_CONV) && conv_end;
      result_code <= result_r;
    end
  end

  assign bus.sda_s_o  = sda_o_r;
  assign bus.sda_s_oe = sda_low_r;

endmodule : airs_dev
`default_nettype wire

/* File: airs_defs.svh */
// Constants shared by both ends of the converter read link
`ifndef AIRS_DEFS_SVH
`define AIRS_DEFS_SVH

// ------------------------------------------------------------
// Clock and timing
// ------------------------------------------------------------
`define AIRS_CLK_NS       4
`define AIRS_POR_NS       500000
`define AIRS_POR_CYCLES   (`AIRS_POR_NS / `AIRS_CLK_NS)
`define AIRS_CONV_NS      16600000
`define AIRS_CONV_CYCLES  (`AIRS_CONV_NS / `AIRS_CLK_NS)
`define AIRS_SCL_NS       2500
`define AIRS_QTR_CYCLES   (`AIRS_SCL_NS / (4 * `AIRS_CLK_NS))

// ------------------------------------------------------------
// Link framing
// ------------------------------------------------------------
`define AIRS_ADDR         7'h14
`define AIRS_ADDR_RD      8'h29
`define AIRS_BYTE_BITS    5'h08
`define AIRS_RES_BITS     5'h10
`define AIRS_MID_SCALE    20'sh08000
`define AIRS_FULL_SCALE   20'sh0ffff
`define AIRS_SLOT_ACK     5'h08
`define AIRS_SLOT_MACK    5'h11
`define AIRS_SLOT_LAST    5'h1a

`endif

/* File: airs_pkg.sv */
// Types shared by both ends of the converter read link
package airs_pkg;
  typedef enum logic [1:0] {DEV_CONV, DEV_SLEEP, DEV_OUTPUT} airs_dev_state_t;
  typedef enum logic [2:0] {L_IDLE, L_ADDR, L_ACK, L_ACKH, L_DATA, L_MACK, L_IGNORE} airs_link_state_t;
  typedef enum logic [1:0] {H_IDLE, H_START, H_BIT, H_STOP} airs_host_state_t;
endpackage : airs_pkg

/* File: airs_if.sv */
// Open-drain two-wire link joining master and converter end
`timescale 1ns/1ps
`default_nettype none
interface airs_if;
  logic scl_o;
  logic scl_oe;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic scl;
  logic sda;

  // Wired-AND with pull-up: a line is low only while someone pulls it low
  assign scl = ~(scl_oe & ~scl_o);
  assign sda = ~((sda_m_oe & ~sda_m_o) | (sda_s_oe & ~sda_s_o));

  modport dev  (input scl, input sda, output sda_s_o, output sda_s_oe);
  modport host (input scl, input sda, output scl_o, output scl_oe, output sda_m_o, output sda_m_oe);
endinterface : airs_if
`default_nettype wire

/* File: airs_host.sv */
// Master end: issues address and reads or discards a result
`timescale 1ns/1ps
`default_nettype none
`include "airs_defs.svh"
module airs_host
  import airs_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  airs_if.host             bus,
  input  wire logic        rd_req,
  input  wire logic        rd_discard,
  output logic             rd_busy,
  output logic             rd_done,
  output logic             rd_nak,
  output logic      [15:0] rd_data
);

  // ------------------------------------------------------------
  // Quarter-period tick and data sampling
  // ------------------------------------------------------------
  // One tick per quarter bit gives 400 kbit/s; no clock stretching is honoured
  logic [11:0] div_r;
  logic        tick;
  assign tick = (div_r == 12'(`AIRS_QTR_CYCLES - 1));

  always_ff @(posedge core_clk) begin
    if (rst || tick) begin
      div_r <= 12'h000;
    end else begin
      div_r <= div_r + 12'h001;
    end
  end

  logic sda_m1, sda_m2;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sda_m1 <= 1'b1;
      sda_m2 <= 1'b1;
    end else begin
      sda_m1 <= bus.sda;
      sda_m2 <= sda_m1;
    end
  end

  // ------------------------------------------------------------
  // Transfer sequencer
  // ------------------------------------------------------------
  airs_host_state_t hstate_r;
  logic [1:0]       ph_r;
  logic [4:0]       slot_r;
  logic             discard_r;
  logic             scl_low_r;
  logic             sda_low_r;
  logic [7:0]       addr_sh_r;

  always_ff @(posedge core_clk) begin
    if (rst) begin
      hstate_r  <= H_IDLE;
      ph_r      <= 2'h0;
      slot_r    <= 5'h00;
      discard_r <= 1'b0;
      scl_low_r <= 1'b0;
      sda_low_r <= 1'b0;
      addr_sh_r <= 8'h00;
      rd_busy   <= 1'b0;
      rd_done   <= 1'b0;
      rd_nak    <= 1'b0;
      rd_data   <= 16'h0000;
    end else begin
      rd_done <= 1'b0;
      case (hstate_r)
        H_IDLE: begin
          if (rd_req) begin
            hstate_r  <= H_START;
            discard_r <= rd_discard;
            addr_sh_r <= `AIRS_ADDR_RD;
            rd_busy   <= 1'b1;
            rd_nak    <= 1'b0;
            ph_r      <= 2'h0;
          end
        end
        H_START: begin
          if (tick) begin
            sda_low_r <= 1'b1;
            hstate_r  <= H_BIT;
            slot_r    <= 5'h00;
            ph_r      <= 2'h3;
          end
        end
        H_BIT: begin
          if (tick) begin
            ph_r <= ph_r + 2'h1;
            case (ph_r)
              2'h3: scl_low_r <= 1'b1;
              2'h0: begin
                // Data moves only with the clock low
                if (slot_r < `AIRS_SLOT_ACK) begin
                  sda_low_r <= ~addr_sh_r[7];
                  addr_sh_r <= {addr_sh_r[6:0], 1'b0};
                end else begin
                  sda_low_r <= (slot_r == `AIRS_SLOT_MACK);
                end
              end
              2'h1: scl_low_r <= 1'b0;
              default: begin
                slot_r <= slot_r + 5'h01;
                if (slot_r == `AIRS_SLOT_ACK) begin
                  rd_nak <= sda_m2;
                  if (sda_m2 || discard_r) begin
                    hstate_r <= H_STOP;
                  end
                  // The last slot is the closing not-acknowledge, not a data bit
                end else if (slot_r > `AIRS_SLOT_ACK && slot_r != `AIRS_SLOT_MACK && slot_r != `AIRS_SLOT_LAST) begin
                  rd_data <= {rd_data[14:0], sda_m2};
                end
                if (slot_r == `AIRS_SLOT_LAST) begin
                  hstate_r <= H_STOP;
                end
              end
            endcase
          end
        end
        H_STOP: begin
          if (tick) begin
            ph_r <= ph_r + 2'h1;
            case (ph_r)
              2'h3: scl_low_r <= 1'b1;
              2'h0: sda_low_r <= 1'b1;
              2'h1: scl_low_r <= 1'b0;
              default: begin
                sda_low_r <= 1'b0;
                rd_busy   <= 1'b0;
                rd_done   <= 1'b1;
                hstate_r  <= H_IDLE;
              end
            endcase
          end
        end
        default: hstate_r <= H_IDLE;
      endcase
    end
  end

  // ------------------------------------------------------------
  // Open-drain pins
  // ------------------------------------------------------------
  logic zero_r;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      zero_r <= 1'b0;
    end else begin
      zero_r <= 1'b0;
    end
  end

  assign bus.scl_o    = zero_r;
  assign bus.scl_oe   = scl_low_r;
  assign bus.sda_m_o  = zero_r;
  assign bus.sda_m_oe = sda_low_r;

endmodule : airs_host
`default_nettype wire

/* File: airs_checker.sv */
// Concurrent checks on the two-wire link between master and converter end
`timescale 1ns/1ps
`default_nettype none
module airs_checker (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_m_o,
  input wire logic sda_m_oe,
  input wire logic sda_s_o,
  input wire logic sda_s_oe,
  input wire logic scl,
  input wire logic sda,
  input wire logic conv_busy
);
  // ------------------------------------------------------------
  // Helper logic
  // ------------------------------------------------------------
  logic       scl_q_r;
  logic       sda_q_r;
  logic [4:0] rise_cnt_r;
  logic       start_w;

  assign start_w = scl && scl_q_r && sda_q_r && !sda;

  always_ff @(posedge core_clk) begin
    scl_q_r <= scl;
    sda_q_r <= sda;
  end

  // Counts clock rises since the last start so each slot of a frame is known
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rise_cnt_r <= 5'h00;
    end else if (start_w) begin
      rise_cnt_r <= 5'h00;
    end else if (scl && !scl_q_r && rise_cnt_r != 5'h1f) begin
      rise_cnt_r <= rise_cnt_r + 5'h01;
    end
  end

  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_start;
    start_w;
  endsequence
  sequence s_free2;
    !sda_s_oe ##1 !sda_s_oe;
  endsequence

  property p_open_drain;
    sda_s_oe |-> !sda_s_o;
  endproperty
  property p_busy_quiet;
    conv_busy && $past(conv_busy) |-> !sda_s_oe;
  endproperty
  property p_change_low;
    $changed(sda_s_oe) |-> !scl;
  endproperty
  property p_hold_high;
    $rose(scl) |-> $stable(sda_s_oe) [*8];
  endproperty
  property p_addr_quiet;
    rise_cnt_r < 5'h08 |-> !sda_s_oe;
  endproperty
  property p_ack_pull;
    $rose(scl) && rise_cnt_r == 5'h08 && !conv_busy |-> sda_s_oe;
  endproperty
  property p_mack_free;
    $rose(scl) && (rise_cnt_r == 5'h11 || rise_cnt_r == 5'h1a) |-> !sda_s_oe;
  endproperty
  property p_start_free;
    s_start |-> s_free2;
  endproperty
  property p_scl_master;
    !scl |-> scl_oe && !scl_o && !(sda_m_oe && sda_m_o);
  endproperty

  a_open_drain: assert property (p_open_drain)
    else $error("converter end drove the data line high");
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("data line pulled while converting");
  a_change_low: assert property (p_change_low)
    else $error("converter end changed data while clock high");
  a_hold_high: assert property (p_hold_high)
    else $error("data moved right after clock rise");
  a_addr_quiet: assert property (p_addr_quiet)
    else $error("data line pulled during address bits");
  a_ack_pull: assert property (p_ack_pull)
    else $error("ready converter did not acknowledge");
  a_mack_free: assert property (p_mack_free)
    else $error("data line held in master slot");
  a_start_free: assert property (p_start_free)
    else $error("data line held after start");
  a_scl_master: assert property (p_scl_master)
    else $error("clock low without master pulling it");
endmodule : airs_checker
`default_nettype wire

/* File: testbench.sv */
// Self-checking bench joining master end and converter end
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin miscompares++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module testbench;
  import airs_pkg::*;
  // Conversion must outlast address plus ack so the first read is refused
  localparam int unsigned POR_N  = 20;
  localparam int unsigned CONV_N = 6000;

  logic               core_clk     = 1'b0;
  logic               rst          = 1'b1;
  logic               rd_req       = 1'b0;
  logic               rd_discard   = 1'b0;
  logic signed [19:0] diff_in      = 20'sh00000;
  logic               scl_d_r      = 1'b1;
  logic               sda_d_r      = 1'b1;
  logic        [27:0] wire_bits    = 28'h0000000;
  logic               conv_busy;
  logic               result_new;
  logic        [15:0] result_code;
  logic               rd_busy;
  logic               rd_done;
  logic               rd_nak;
  logic        [15:0] rd_data;
  logic        [19:0] tbl_in [3]   = '{20'h7ffff, 20'hf63c0, 20'hfffff};
  logic        [15:0] tbl_exp [3]  = '{16'hffff, 16'h0000, 16'h7fff};
  int                 miscompares  = 0;
  int                 total_checks = 0;
  int                 new_cnt      = 0;

  airs_if link_if ();

  airs_dev #(.POR_CYCLES(POR_N), .CONV_CYCLES(CONV_N)) airs_dev_i (
    .core_clk(core_clk), .rst(rst), .bus(link_if), .diff_in(diff_in),
    .conv_busy(conv_busy), .result_new(result_new), .result_code(result_code));

  airs_host airs_host_i (
    .core_clk(core_clk), .rst(rst), .bus(link_if), .rd_req(rd_req), .rd_discard(rd_discard),
    .rd_busy(rd_busy), .rd_done(rd_done), .rd_nak(rd_nak), .rd_data(rd_data));

  airs_checker airs_checker_i (
    .core_clk(core_clk), .rst(rst), .scl_o(link_if.scl_o), .scl_oe(link_if.scl_oe),
    .sda_m_o(link_if.sda_m_o), .sda_m_oe(link_if.sda_m_oe), .sda_s_o(link_if.sda_s_o),
    .sda_s_oe(link_if.sda_s_oe), .scl(link_if.scl), .sda(link_if.sda), .conv_busy(conv_busy));

  always #2 core_clk = ~core_clk;

  // ------------------------------------------------------------
  // Wire monitor: bits seen at clock rises since the last start
  // ------------------------------------------------------------
  always @(posedge core_clk) begin
    scl_d_r <= link_if.scl;
    sda_d_r <= link_if.sda;
    // The clock rise that sets up a STOP is recorded as a trailing bit too
    if (link_if.scl && scl_d_r && sda_d_r && !link_if.sda) begin
      wire_bits <= 28'h0000000;
    end else if (link_if.scl && !scl_d_r) begin
      wire_bits <= {wire_bits[26:0], link_if.sda};
    end
    if (result_new === 1'b1) begin
      new_cnt <= new_cnt + 1;
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic conclude();
    if (miscompares == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : conclude

  task automatic do_read(input logic discard);
    int n;
    n = 0;
    @(posedge core_clk);
    rd_req     <= 1'b1;
    rd_discard <= discard;
    @(posedge core_clk);
    rd_req <= 1'b0;
    @(posedge core_clk);
    `CHK(rd_busy, 1'b1)
    while (rd_done !== 1'b1 && n < 20000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 20000) begin
      miscompares++;
      conclude();
    end
    `CHK(rd_busy, 1'b0)
  endtask : do_read

  task automatic wait_conv();
    int n;
    n = 0;
    while (conv_busy !== 1'b0 && n < 10000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 10000) begin
      miscompares++;
      conclude();
    end
    repeat (50) @(posedge core_clk);
  endtask : wait_conv

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (6) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    `CHK(link_if.scl, 1'b1)
    `CHK(link_if.sda, 1'b1)
    `CHK(conv_busy, 1'b1)
    do_read(1'b0);
    `CHK(rd_nak, 1'b1)
    wait_conv();
    `CHK(result_code, 16'h8000)
    `CHK(new_cnt, 1)
    do_read(1'b1);
    `CHK(rd_nak, 1'b0)
    `CHK(wire_bits[9:0], {8'h29, 1'b0, 1'b0})
    repeat (16) @(posedge core_clk);
    `CHK(conv_busy, 1'b1)
    for (int i = 0; i < 3; i++) begin
      diff_in <= tbl_in[i];
      wait_conv();
      // A later input change must not disturb the held result
      diff_in <= ~tbl_in[i];
      repeat (50) @(posedge core_clk);
      `CHK(result_code, tbl_exp[i])
      `CHK(new_cnt, i + 2)
      do_read(1'b0);
      `CHK(rd_nak, 1'b0)
      `CHK(rd_data, tbl_exp[i])
      `CHK(wire_bits, {8'h29, 1'b0, tbl_exp[i][15:8], 1'b0, tbl_exp[i][7:0], 1'b1, 1'b0})
      `CHK(conv_busy, 1'b1)
    end
    conclude();
  end
endmodule : testbench
`default_nettype wire
